// *** logic/cft_consts.vh ***
// Constants for the CAN filter and bit-timing register slice
`ifndef CFT_CONSTS_VH
`define CFT_CONSTS_VH
`define CFT_OFF_FIFO      12'h000
`define CFT_OFF_CFG2      12'h004
`define CFT_OFF_BUFSEL    12'h008
`define CFT_OFF_MSKSEL    12'h00C
`define CFT_OFF_MATCHCTL  12'h010
`define CFT_OFF_MATCHSTAT 12'h014
`define CFT_OFF_EID0      12'h040
`define CFT_EID_LAST      12'h07C
`define CFT_CFG2_MASK     16'h47FF
`define CFT_FIFO_MASK     16'h3F3F
`define CFT_WAKE_BIT      14
`define CFT_PH2_LSB       8
`define CFT_FREE_BIT      7
`define CFT_SAM_BIT       6
`define CFT_PH1_LSB       3
`define CFT_PROP_LSB      0
`define CFT_FIFO_CODE     4'hF
`define CFT_MSK_RSVD      2'h3
`define CFT_IPT_TQ        4'h2
`define CFT_NUM_FILT      16
`define CFT_HTRANS_NSEQ   2'h2
`define CFT_HSIZE_WORD    3'h2
`endif

// *** logic/cft_filter_match.v ***
// One acceptance filter extended-identifier compare
`timescale 1ns/100ps
module cft_filter_match (
   // Incoming identifier, stored value and selected mask
   input  wire [15:0] msg_eid,
   input  wire [15:0] filt_eid,
   input  wire [15:0] mask,
   // Match result
   output wire        hit
);
   // Mask bit 1 means the position must compare
   assign hit = ~|((msg_eid ^ filt_eid) & mask); // RULE7
endmodule // cft_filter_match

// *** logic/cft_regs.v ***
// AHB-Lite register slice for CAN filters, bit timing and FIFO status
// Behaviour
// RULE1 - Read-only FIFO word: current pointer bits 13-8, next-read pointer bits 5-0.
// RULE2 - Unused bits read zero; writes to them are ignored.
// RULE3 - Bit 14 of timing register selects line filter for wake-up detection.
// RULE4 - Propagation, phase 1, phase 2 fields last value plus one quantum.
// RULE5 - Filters 12-15 get 4-bit buffer select; 1111 routes into receive FIFO.
// RULE6 - Sixteen writable 16-bit extended-identifier filters, unknown after reset.
// RULE7 - Filter matches when every unmasked identifier bit equals stored bit.
// RULE8 - Filters 0-7 get 2-bit mask source; 11 reserved.
// RULE9 - Bit 6 set samples bus three times, clear samples once.
// RULE10 - Bit 7 set: phase 2 free; clear: max of phase 1 and IPT.
`timescale 1ns/100ps
`include "cft_consts.vh"
module cft_regs (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Frame engine side
   input  wire [5:0]  fifo_current_buffer_pointer,
   input  wire [5:0]  fifo_next_read_pointer,
   input  wire [15:0] msg_eid,
   input  wire        msg_eid_valid,
   input  wire [15:0] accept_mask0,
   input  wire [15:0] accept_mask1,
   input  wire [15:0] accept_mask2,
   // Timing and routing outputs
   output reg         wakeup_line_filter_select,
   output reg         triple_sample_select,
   output reg  [3:0]  propagation_tq,
   output reg  [3:0]  phase_one_tq,
   output reg  [3:0]  phase_two_tq,
   output reg  [15:0] filter_hit,
   output reg         hit_valid,
   output reg  [3:0]  hit_buffer_select,
   output reg         hit_to_fifo
);
   reg  [15:0] cfg2_reg;
   reg  [15:0] bufsel_reg;
   reg  [15:0] msksel_reg;
   reg  [15:0] filt_en_reg;
   reg  [15:0] eid_mem [0:`CFT_NUM_FILT-1];
   reg  [5:0]  cur_ptr_reg;
   reg  [5:0]  nxt_ptr_reg;
   reg         wr_pend_reg;
   reg  [11:0] wr_addr_reg;
   reg  [15:0] rd_next;
   wire        take;
   wire [15:0] wd;
   wire [3:0]  eid_idx;
   wire [15:0] hit_raw;
   wire [3:0]  prop_len;
   wire [3:0]  ph1_len;
   wire [3:0]  ph2_len;
   wire [3:0]  ph2_auto;
   reg  [3:0]  first_idx;
   reg         any_hit;
   integer     k;

   assign take = hsel & hready & (htrans == `CFT_HTRANS_NSEQ);
   assign wd   = hwdata[15:0];
   assign eid_idx = wr_addr_reg[5:2];

   cft_seg_len u_prop (.field(cfg2_reg[`CFT_PROP_LSB+2:`CFT_PROP_LSB]), .len_tq(prop_len));
   cft_seg_len u_ph1  (.field(cfg2_reg[`CFT_PH1_LSB+2:`CFT_PH1_LSB]),   .len_tq(ph1_len));
   cft_seg_len u_ph2  (.field(cfg2_reg[`CFT_PH2_LSB+2:`CFT_PH2_LSB]),   .len_tq(ph2_len));

   // Auto phase 2 follows phase 1 but never shorter than processing time
   assign ph2_auto = (ph1_len > `CFT_IPT_TQ) ? ph1_len : `CFT_IPT_TQ; // RULE10

   genvar g;
   generate
      for (g = 0; g < `CFT_NUM_FILT; g = g + 1) begin : g_filt
         wire [1:0]  src;
         wire [15:0] msk;
         wire        cmp_hit;
         // Filters 8-15 have no selector in this slice; they use mask 0
         if (g < 8) begin : g_sel
            assign src = msksel_reg[2*g+1:2*g]; // RULE8
         end else begin : g_nosel
            assign src = 2'h0;
         end
         assign msk = (src == 2'h0) ? accept_mask0 :
                      (src == 2'h1) ? accept_mask1 :
                      (src == 2'h2) ? accept_mask2 : 16'hFFFF; // RULE8
         cft_filter_match u_match (
            .msg_eid  (msg_eid),
            .filt_eid (eid_mem[g]),
            .mask     (msk),
            .hit      (cmp_hit)
         );
         // Reserved code never matches, so a bad setting cannot accept traffic
         assign hit_raw[g] = cmp_hit & (src != `CFT_MSK_RSVD); // RULE8
      end
   endgenerate

   // Lowest numbered enabled hit wins
   always @* begin
      first_idx = 4'h0;
      any_hit   = 1'b0;
      for (k = `CFT_NUM_FILT - 1; k >= 0; k = k - 1) begin
         if (hit_raw[k] & filt_en_reg[k] &
             ~((k < 8) && (msksel_reg[2*(k%8)+:2] == `CFT_MSK_RSVD))) begin
            first_idx = k[3:0];
            any_hit   = 1'b1;
         end
      end
   end

   // Read mux, reserved bits forced to zero
   always @* begin
      rd_next = 16'h0000;
      if (haddr >= `CFT_OFF_EID0 && haddr <= `CFT_EID_LAST)
         rd_next = eid_mem[haddr[5:2]];
      else begin
         case (haddr)
            `CFT_OFF_FIFO:      rd_next = {2'h0, cur_ptr_reg, 2'h0, nxt_ptr_reg}; // RULE1 RULE2
            `CFT_OFF_CFG2:      rd_next = cfg2_reg & `CFT_CFG2_MASK; // RULE2
            `CFT_OFF_BUFSEL:    rd_next = bufsel_reg;
            `CFT_OFF_MSKSEL:    rd_next = msksel_reg;
            `CFT_OFF_MATCHCTL:  rd_next = filt_en_reg;
            `CFT_OFF_MATCHSTAT: rd_next = filter_hit;
            default:            rd_next = 16'h0000;
         endcase
      end
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         cur_ptr_reg <= 6'h00;
         nxt_ptr_reg <= 6'h00;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= take & hwrite;
         if (take)
            wr_addr_reg <= haddr;
         if (take & ~hwrite)
            hrdata <= {16'h0000, rd_next};
         cur_ptr_reg <= fifo_current_buffer_pointer; // RULE1
         nxt_ptr_reg <= fifo_next_read_pointer; // RULE1
      end
   end

   // Control registers written in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg2_reg    <= 16'h0000;
         bufsel_reg  <= 16'h0000;
         msksel_reg  <= 16'h0000;
         filt_en_reg <= 16'h0000;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            `CFT_OFF_CFG2:     cfg2_reg    <= wd & `CFT_CFG2_MASK; // RULE2 RULE3
            `CFT_OFF_BUFSEL:   bufsel_reg  <= wd; // RULE5
            `CFT_OFF_MSKSEL:   msksel_reg  <= wd; // RULE8
            `CFT_OFF_MATCHCTL: filt_en_reg <= wd;
            default:           cfg2_reg    <= cfg2_reg;
         endcase
      end
   end

   // Identifier store has no reset: contents undefined until written
   always @(posedge hclk) begin
      if (wr_pend_reg && wr_addr_reg >= `CFT_OFF_EID0 && wr_addr_reg <= `CFT_EID_LAST)
         eid_mem[eid_idx] <= wd; // RULE6
   end

   // Registered timing and match outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wakeup_line_filter_select <= 1'b0;
         triple_sample_select      <= 1'b0;
         propagation_tq            <= 4'h1;
         phase_one_tq              <= 4'h1;
         phase_two_tq              <= 4'h2;
         filter_hit                <= 16'h0000;
         hit_valid                 <= 1'b0;
         hit_buffer_select         <= 4'h0;
         hit_to_fifo               <= 1'b0;
      end else begin
         wakeup_line_filter_select <= cfg2_reg[`CFT_WAKE_BIT]; // RULE3
         triple_sample_select      <= cfg2_reg[`CFT_SAM_BIT]; // RULE9
         propagation_tq            <= prop_len; // RULE4
         phase_one_tq              <= ph1_len; // RULE4
         phase_two_tq <= cfg2_reg[`CFT_FREE_BIT] ? ph2_len : ph2_auto; // RULE10
         hit_valid <= msg_eid_valid & any_hit;
         if (msg_eid_valid)
            filter_hit <= hit_raw & filt_en_reg; // RULE7
         if (msg_eid_valid & any_hit) begin
            // Only filters 12-15 carry a routing field here
            if (first_idx[3:2] == 2'h3) begin
               hit_buffer_select <= bufsel_reg[{first_idx[1:0], 2'h0}+:4]; // RULE5
               hit_to_fifo <= (bufsel_reg[{first_idx[1:0], 2'h0}+:4] == `CFT_FIFO_CODE); // RULE5
            end else begin
               hit_buffer_select <= 4'h0;
               hit_to_fifo       <= 1'b0;
            end
         end
      end
   end
endmodule // cft_regs

// *** logic/cft_seg_len.v ***
// Segment length decoder: field value plus one time quantum
`timescale 1ns/100ps
module cft_seg_len (
   // Field in
   input  wire [2:0] field,
   // Length in time quanta
   output wire [3:0] len_tq
);
   assign len_tq = {1'b0, field} + 4'h1; // RULE4
endmodule // cft_seg_len

// *** tb/cft_engine_model.sv ***
// Frame engine stand-in driving identifiers, masks and pointers
`timescale 1ns/100ps
module cft_engine_model (
   // Bench command
   input  wire        hclk,
   input  wire        fire,
   input  wire [15:0] ident,
   // Toward the slice
   output reg  [15:0] msg_eid = 16'h0000,
   output reg         msg_eid_valid = 1'b0,
   output wire [5:0]  cur_ptr,
   output wire [5:0]  nxt_ptr,
   output wire [15:0] mask0,
   output wire [15:0] mask1,
   output wire [15:0] mask2
);
   reg [4:0] ptr_reg = 5'h00;
   assign cur_ptr = {1'b0, ptr_reg};
   assign nxt_ptr = {1'b0, ptr_reg - 5'h01};
   assign mask0 = 16'hFFFF;
   assign mask1 = 16'hFF00;
   assign mask2 = 16'h00F0;
   // Identifier goes stale after the pulse so a held value is never seen
   always @(posedge hclk) begin
      msg_eid_valid <= fire;
      msg_eid <= fire ? ident : ~msg_eid;
      ptr_reg <= ptr_reg + {4'h0, fire};
   end
endmodule // cft_engine_model

// *** tb/cft_regs_asserts.sv ***
// Port assertions for the CAN filter and timing slice
`timescale 1ns/100ps
`include "cft_consts.vh"
module cft_regs_asserts (
   // Bus
   input wire        hclk, hresetn, hsel, hwrite, hready,
   input wire [11:0] haddr,
   input wire [1:0]  htrans,
   input wire [31:0] hwdata, hrdata,
   // Engine side and timing
   input wire [5:0]  fifo_current_buffer_pointer, fifo_next_read_pointer,
   input wire        msg_eid_valid, hit_valid, hit_to_fifo,
   input wire        wakeup_line_filter_select, triple_sample_select,
   input wire [3:0]  propagation_tq, phase_one_tq, phase_two_tq, hit_buffer_select,
   input wire [15:0] filter_hit
);
   reg  [13:0] dph_reg;
   wire        take   = hsel & hready & (htrans == `CFT_HTRANS_NSEQ);
   wire        cfg_wr = dph_reg[13] & (dph_reg[11:0] == `CFT_OFF_CFG2);
   wire        ptr_rd = dph_reg[12] & (dph_reg[11:0] == `CFT_OFF_FIFO);
   // Data phase trails its address phase by one cycle
   always @(posedge hclk or negedge hresetn)
      if (!hresetn) dph_reg <= 14'h0000;
      else dph_reg <= {take & hwrite, take & ~hwrite, haddr};
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Timing outputs trail the register by one more cycle
   chk_prop_len: assert property (cfg_wr |=> ##1
      propagation_tq == {1'b0, $past(hwdata[2:0], 2)} + 4'h1) else $error("prop length");
   chk_phase_free: assert property (cfg_wr && hwdata[7] |=> ##1
      phase_two_tq == {1'b0, $past(hwdata[10:8], 2)} + 4'h1) else $error("phase two free");
   chk_phase_tied: assert property (cfg_wr && !hwdata[7] |=> ##1
      phase_two_tq == (phase_one_tq > `CFT_IPT_TQ ? phase_one_tq : `CFT_IPT_TQ))
      else $error("phase two tied");
   chk_wake_sel: assert property (cfg_wr |=> ##1
      wakeup_line_filter_select == $past(hwdata[14], 2)) else $error("wake filter");
   chk_triple_sel: assert property (cfg_wr |=> ##1
      triple_sample_select == $past(hwdata[6], 2)) else $error("sample mode");
   chk_ptr_word: assert property (ptr_rd |-> hrdata == {18'h0,
      $past(fifo_current_buffer_pointer, 2), 2'b00, $past(fifo_next_read_pointer, 2)})
      else $error("pointer word");
   chk_hit_cause: assert property (hit_valid |->
      $past(msg_eid_valid) && filter_hit != 16'h0000) else $error("hit without compare");
   chk_fifo_route: assert property (hit_to_fifo |->
      hit_buffer_select == `CFT_FIFO_CODE) else $error("fifo route");
endmodule // cft_regs_asserts
bind cft_regs cft_regs_asserts u_cft_regs_asserts (.*);

// *** tb/cft_regs_bench.sv ***
// Self-checking bench for the CAN filter and timing slice
`timescale 1ns/100ps
`include "cft_consts.vh"
module cft_regs_bench;
   reg          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdph = 1'b0;
   reg          fire = 1'b0;
   reg  [11:0]  haddr = 12'h000;
   reg  [1:0]   htrans = 2'h0;
   reg  [31:0]  hwdata = 32'h0, r;
   reg  [15:0]  ident = 16'h0, en, filt [16];
   wire [31:0]  hrdata;
   wire         hreadyout, hresp, mv, hv, hf;
   wire [3:0]   hb;
   logic [31:0] qh [$];
   wire [15:0]  me, mask0, mask1, mask2;
   wire [5:0]   cur_ptr, nxt_ptr;
   logic [31:0] q [$];
   integer      failures = 0, check_count = 0, n, p;
   always #12.5 hclk = ~hclk;
   cft_engine_model u_cft_engine_model (.hclk(hclk), .fire(fire), .ident(ident),
      .msg_eid(me), .msg_eid_valid(mv), .cur_ptr(cur_ptr), .nxt_ptr(nxt_ptr),
      .mask0(mask0), .mask1(mask1), .mask2(mask2));
   cft_regs u_cft_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(`CFT_HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .fifo_current_buffer_pointer(cur_ptr), .fifo_next_read_pointer(nxt_ptr),
      .msg_eid(me), .msg_eid_valid(mv), .accept_mask0(mask0), .accept_mask1(mask1),
      .accept_mask2(mask2), .wakeup_line_filter_select(), .triple_sample_select(),
      .propagation_tq(), .phase_one_tq(), .phase_two_tq(), .filter_hit(),
      .hit_valid(hv), .hit_buffer_select(hb), .hit_to_fifo(hf));
   // Mask source codes are fixed at E4E4, so filter i below 8 uses code i mod 4
   function automatic [15:0] hits(input [15:0] e, input [15:0] en_v);
      integer i;
      reg [1:0] s;
      for (i = 0; i < 16; i++) begin
         s = (i < 8) ? i[1:0] : 2'b00;
         hits[i] = en_v[i] && s != 2'b11 && ((e ^ filt[i]) &
            (s == 2'b00 ? mask0 : s == 2'b01 ? mask1 : mask2)) == 16'h0000;
      end
   endfunction
   // Lowest hit wins; only filters 12 to 15 route, per buffer select 5FFF
   function automatic [4:0] route(input [15:0] h);
      integer i;
      reg [15:0] s4;
      route = 5'h00;
      for (i = 15; i >= 0; i--) begin
         s4 = 16'h5FFF >> (4 * (i % 4));
         if (h[i]) route = (i < 12) ? 5'h00 : {s4[3:0] == 4'hF, s4[3:0]};
      end
   endfunction
   task bus(input w, input [11:0] a, input [31:0] d);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, `CFT_HTRANS_NSEQ, a, w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {htrans, hwdata, rdph} <= {2'h0, d, ~w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, rdph} <= 2'b00;
   endtask
   task rd(input [11:0] a, input [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      // A routing result that never came counts against the run
      if (qh.size() != 0) failures++;
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Results are matched in issue order
   always @(posedge hclk)
      if (rdph) cmp(hrdata, q.pop_front());
   always @(posedge hclk)
      if (hv) cmp({27'h0, hf, hb}, qh.pop_front());
   initial begin
      r = $urandom(32'h0a592836);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`CFT_OFF_BUFSEL, 32'h0);
      rd(`CFT_OFF_MSKSEL, 32'h0);
      rd(12'h030, 32'h0);
      // Upper half and reserved bits carry junk that must drop out
      for (n = 0; n < 12; n++) begin
         r = $urandom;
         r[7] = n[0];
         p = n % 3;
         bus(1'b1, {p[9:0] + 10'h001, 2'b00}, r);
         rd({p[9:0] + 10'h001, 2'b00}, {16'h0, r[15:0] & (p == 0 ? `CFT_CFG2_MASK : 16'hFFFF)});
      end
      bus(1'b1, `CFT_OFF_FIFO, 32'hFFFFFFFF);
      rd(`CFT_OFF_FIFO, {18'h0, cur_ptr, 2'b00, nxt_ptr});
      for (n = 0; n < 16; n++) begin
         filt[n] = $urandom;
         bus(1'b1, `CFT_OFF_EID0 + {n[9:0], 2'b00}, {16'h0, filt[n]});
      end
      for (n = 0; n < 16; n++) rd(`CFT_OFF_EID0 + {n[9:0], 2'b00}, {16'h0, filt[n]});
      bus(1'b1, `CFT_OFF_MSKSEL, 32'h0000E4E4);
      bus(1'b1, `CFT_OFF_BUFSEL, 32'h00005FFF);
      // First pass lets only filters 12 to 15 win; 12 goes to FIFO, 15 to a buffer
      for (p = 0; p < 2; p++) begin
         en = p ? $urandom : 16'hF000;
         bus(1'b1, `CFT_OFF_MATCHCTL, {16'h0, en});
         for (n = 0; n < 16; n++) begin
            @(posedge hclk);
            // Bit 8 flips outside mask 2 but inside masks 0 and 1; code 11 sees exact ids
            ident <= filt[n] ^ ((n % 4 == 1 || n % 4 == 2) ? 16'h0100 : 16'h0000);
            fire <= 1'b1;
            @(posedge hclk);
            fire <= 1'b0;
            if (hits(ident, en) != 16'h0000) qh.push_back({27'h0, route(hits(ident, en))});
            repeat (3) @(posedge hclk);
            rd(`CFT_OFF_MATCHSTAT, {16'h0, hits(ident, en)});
            rd(`CFT_OFF_FIFO, {18'h0, cur_ptr, 2'b00, nxt_ptr});
         end
      end
      conclude;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      conclude;
   end
endmodule // cft_regs_bench
